// ---- logic/kfs_pkg.sv ----
// package: register map, field positions and carriers for the fec status bank
package kfs_pkg;
  localparam int unsigned ADDR_W = 16;
  localparam int unsigned DATA_W = 16;
  localparam logic [15:0] OFS_LOCAL_TRAINING_STATUS = 16'h009b;
  localparam logic [15:0] OFS_GIG_BACKPLANE_STATUS = 16'h00a1;
  localparam logic [15:0] OFS_FEC_CAPABILITY = 16'h00aa;
  localparam logic [15:0] OFS_FEC_CONTROL = 16'h00ab;
  localparam logic [15:0] OFS_FEC_CORR_LOW = 16'h00ac;
  localparam logic [15:0] OFS_FEC_CORR_HIGH = 16'h00ad;
  localparam logic [15:0] OFS_FEC_UNCORR_LOW = 16'h00ae;
  localparam logic [15:0] OFS_FEC_UNCORR_HIGH = 16'h00af;
  localparam logic [15:0] RST_LOCAL_TRAINING_STATUS = 16'h0000;
  localparam logic [15:0] RST_GIG_BACKPLANE_STATUS = 16'h3000;
  localparam logic [15:0] RST_FEC_CAPABILITY = 16'h0003;
  localparam logic [15:0] RST_FEC_CONTROL = 16'h0000;
  localparam logic [15:0] RST_COUNT_HALF = 16'h0000;
  localparam logic [31:0] RST_COUNT = 32'h0000_0000;
  localparam logic [31:0] COUNT_ONE = 32'h0000_0001;
  localparam logic [31:0] COUNT_MAX = 32'hffff_ffff;
  localparam int unsigned BIT_TRAIN_DONE = 15;
  localparam int unsigned BIT_POST_TAP = 4;
  localparam int unsigned BIT_MAIN_TAP_LO = 2;
  localparam int unsigned BIT_PRE_TAP_LO = 0;
  localparam int unsigned BIT_TX_FAULT_CAP = 13;
  localparam int unsigned BIT_RX_FAULT_CAP = 12;
  localparam int unsigned BIT_TX_FAULT = 11;
  localparam int unsigned BIT_RX_FAULT = 10;
  localparam int unsigned BIT_SIG_PRESENT = 0;
  localparam int unsigned BIT_FEC_ENABLE = 0;
  localparam int unsigned BIT_FEC_ERR_REPORT = 1;
  localparam logic [1:0] COEF_NOT_UPDATED = 2'h0;
  localparam logic [1:0] COEF_UPDATED = 2'h1;
  localparam logic [1:0] COEF_MINIMUM = 2'h2;
  localparam logic [1:0] COEF_MAXIMUM = 2'h3;

  // status inputs from the training machine and the 1g path
  typedef struct packed {
    logic local_training_done;
    logic [1:0] local_post_tap_status;
    logic [1:0] local_main_tap_status;
    logic [1:0] local_pre_tap_status;
    logic gig_tx_fault;
    logic gig_rx_fault;
    logic gig_rx_signal_present;
  } kfs_status_t;

  // one-cycle count events from the fec decoder
  typedef struct packed {
    logic corrected_block;
    logic uncorrected_block;
  } kfs_fec_evt_t;

  // fec control outputs
  typedef struct packed {
    logic fec_enable;
    logic fec_error_report_enable;
  } kfs_fec_ctl_t;
endpackage : kfs_pkg

// ---- logic/kfs_regs.sv ----
// fec and training status register bank behind the management port
module kfs_regs (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic rd_stb,
  input wire logic wr_stb,
  input wire logic [kfs_pkg::ADDR_W-1:0] addr,
  input wire logic [kfs_pkg::DATA_W-1:0] wr_data,
  output logic [kfs_pkg::DATA_W-1:0] rd_data,
  output logic rd_valid,
  input wire kfs_pkg::kfs_status_t status_in,
  input wire kfs_pkg::kfs_fec_evt_t fec_evt,
  output kfs_pkg::kfs_fec_ctl_t fec_ctl
);

  // reset release through two flops
  logic rst_meta_r;
  logic rst_sync_r;
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta_r <= 1'b0;
      rst_sync_r <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_sync_r <= rst_meta_r;
    end
  end
  wire logic rst_int_n = rst_sync_r;

  // status pins come from other logic blocks, two flops before use
  kfs_pkg::kfs_status_t st_meta_r;
  kfs_pkg::kfs_status_t st_r;
  always_ff @(posedge clock or negedge rst_int_n) begin
    if (!rst_int_n) begin
      st_meta_r <= '0;
      st_r <= '0;
    end else begin
      st_meta_r <= status_in;
      st_r <= st_meta_r;
    end
  end

  function automatic logic [31:0] sat_inc(input logic [31:0] v, input logic ev);
    sat_inc = (ev && v != kfs_pkg::COUNT_MAX) ? v + kfs_pkg::COUNT_ONE : v;
  endfunction : sat_inc

  // address decode
  wire logic hit_train = addr == kfs_pkg::OFS_LOCAL_TRAINING_STATUS;
  wire logic hit_gig = addr == kfs_pkg::OFS_GIG_BACKPLANE_STATUS;
  wire logic hit_cap = addr == kfs_pkg::OFS_FEC_CAPABILITY;
  wire logic hit_ctl = addr == kfs_pkg::OFS_FEC_CONTROL;
  wire logic hit_cl = addr == kfs_pkg::OFS_FEC_CORR_LOW;
  wire logic hit_ch = addr == kfs_pkg::OFS_FEC_CORR_HIGH;
  wire logic hit_ul = addr == kfs_pkg::OFS_FEC_UNCORR_LOW;
  wire logic hit_uh = addr == kfs_pkg::OFS_FEC_UNCORR_HIGH;
  wire logic rd_gig = rd_stb && hit_gig;
  wire logic rd_cl = rd_stb && hit_cl;
  wire logic rd_ch = rd_stb && hit_ch;
  wire logic rd_ul = rd_stb && hit_ul;
  wire logic rd_uh = rd_stb && hit_uh;

  // latched-high faults; a fault present in the read cycle keeps the bit set
  logic tx_fault_r;
  logic rx_fault_r;
  wire logic tx_fault_nxt = st_r.gig_tx_fault || (tx_fault_r && !rd_gig);
  wire logic rx_fault_nxt = st_r.gig_rx_fault || (rx_fault_r && !rd_gig);

  // fec control
  kfs_pkg::kfs_fec_ctl_t ctl_r;
  kfs_pkg::kfs_fec_ctl_t ctl_nxt;
  always_comb begin
    ctl_nxt = ctl_r;
    if (wr_stb && hit_ctl) begin
      ctl_nxt.fec_enable = wr_data[kfs_pkg::BIT_FEC_ENABLE];
      ctl_nxt.fec_error_report_enable = wr_data[kfs_pkg::BIT_FEC_ERR_REPORT];
    end
  end
  assign fec_ctl = ctl_r;

  // counters: a low read clears both halves, a high read only the high half; the high-half hold register
  // makes a low-then-high pair coherent even as blocks keep arriving
  logic [31:0] corr_r;
  logic [31:0] uncorr_r;
  logic [15:0] corr_hold_r;
  logic [15:0] uncorr_hold_r;
  logic corr_held_r;
  logic uncorr_held_r;
  wire logic [31:0] corr_inc = sat_inc(corr_r, fec_evt.corrected_block);
  wire logic [31:0] uncorr_inc = sat_inc(uncorr_r, fec_evt.uncorrected_block);
  // a high read clears only the high half, the low half keeps counting
  // a high read served from the hold leaves the live high half alone
  wire logic corr_hi_clr = rd_ch && !corr_held_r;
  wire logic uncorr_hi_clr = rd_uh && !uncorr_held_r;
  wire logic [31:0] corr_nxt = rd_cl ? {corr_inc[31:16], kfs_pkg::RST_COUNT_HALF}
    : corr_hi_clr ? {kfs_pkg::RST_COUNT_HALF, corr_inc[15:0]} : corr_inc;
  wire logic [31:0] uncorr_nxt = rd_ul ? {uncorr_inc[31:16], kfs_pkg::RST_COUNT_HALF}
    : uncorr_hi_clr ? {kfs_pkg::RST_COUNT_HALF, uncorr_inc[15:0]} : uncorr_inc;
  // a low read clears the live high half too once captured, since the hold
  // now owns that value
  wire logic [31:0] corr_nxt_f = rd_cl ? {kfs_pkg::RST_COUNT_HALF, kfs_pkg::RST_COUNT_HALF}
    + {16'h0000, 15'h0000, corr_inc != corr_r} : corr_nxt;
  wire logic [31:0] uncorr_nxt_f = rd_ul ? {kfs_pkg::RST_COUNT_HALF, kfs_pkg::RST_COUNT_HALF}
    + {16'h0000, 15'h0000, uncorr_inc != uncorr_r} : uncorr_nxt;
  wire logic [15:0] corr_hi_view = corr_held_r ? corr_hold_r : corr_r[31:16];
  wire logic [15:0] uncorr_hi_view = uncorr_held_r ? uncorr_hold_r : uncorr_r[31:16];

  // read data mux
  wire logic [15:0] train_word = {st_r.local_training_done, 10'h000,
    st_r.local_post_tap_status[0],
    st_r.local_main_tap_status, st_r.local_pre_tap_status};
  wire logic [15:0] gig_word = kfs_pkg::RST_GIG_BACKPLANE_STATUS
    | ({15'h0000, tx_fault_r} << kfs_pkg::BIT_TX_FAULT)
    | ({15'h0000, rx_fault_r} << kfs_pkg::BIT_RX_FAULT)
    | ({15'h0000, st_r.gig_rx_signal_present} << kfs_pkg::BIT_SIG_PRESENT);
  wire logic [15:0] ctl_word = {14'h0000, ctl_r.fec_error_report_enable, ctl_r.fec_enable};
  wire logic [15:0] rd_mux = hit_train ? train_word
    : hit_gig ? gig_word
    : hit_cap ? kfs_pkg::RST_FEC_CAPABILITY
    : hit_ctl ? ctl_word
    : hit_cl ? corr_r[15:0]
    : hit_ch ? corr_hi_view
    : hit_ul ? uncorr_r[15:0]
    : hit_uh ? uncorr_hi_view
    : 16'h0000;

  always_ff @(posedge clock or negedge rst_int_n) begin
    if (!rst_int_n) begin
      tx_fault_r <= 1'b0;
      rx_fault_r <= 1'b0;
      ctl_r <= '0;
      corr_r <= kfs_pkg::RST_COUNT;
      uncorr_r <= kfs_pkg::RST_COUNT;
      corr_hold_r <= kfs_pkg::RST_COUNT_HALF;
      uncorr_hold_r <= kfs_pkg::RST_COUNT_HALF;
      corr_held_r <= 1'b0;
      uncorr_held_r <= 1'b0;
      rd_data <= kfs_pkg::RST_COUNT_HALF;
      rd_valid <= 1'b0;
    end else begin
      tx_fault_r <= tx_fault_nxt;
      rx_fault_r <= rx_fault_nxt;
      ctl_r <= ctl_nxt;
      corr_r <= corr_nxt_f;
      uncorr_r <= uncorr_nxt_f;
      if (rd_cl) begin
        corr_hold_r <= corr_r[31:16];
        corr_held_r <= 1'b1;
      end else if (rd_ch) begin
        corr_held_r <= 1'b0;
      end
      if (rd_ul) begin
        uncorr_hold_r <= uncorr_r[31:16];
        uncorr_held_r <= 1'b1;
      end else if (rd_uh) begin
        uncorr_held_r <= 1'b0;
      end
      rd_valid <= rd_stb;
      if (rd_stb) begin
        rd_data <= rd_mux;
      end
    end
  end
endmodule : kfs_regs

// ---- verification/kfs_chk.sv ----
// checker: port assertions for the fec status bank
module kfs_chk (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic rd_stb,
  input wire logic wr_stb,
  input wire logic [15:0] addr,
  input wire logic [15:0] wr_data,
  input wire logic [15:0] rd_data,
  input wire logic rd_valid,
  input wire kfs_pkg::kfs_status_t status_in,
  input wire kfs_pkg::kfs_fec_evt_t fec_evt,
  input wire kfs_pkg::kfs_fec_ctl_t fec_ctl
);
  wire rd_trn = rd_stb && addr == kfs_pkg::OFS_LOCAL_TRAINING_STATUS;
  wire rd_gig = rd_stb && addr == kfs_pkg::OFS_GIG_BACKPLANE_STATUS;
  wire rd_ctl = rd_stb && addr == kfs_pkg::OFS_FEC_CONTROL;
  wire wr_ctl = wr_stb && addr == kfs_pkg::OFS_FEC_CONTROL;
  default clocking @(posedge clock);
  endclocking
  default disable iff (!rst_n);
  // status is synchronised, so only settled levels are judged
  sequence calm;
    $stable(status_in)[*4];
  endsequence
  a_train_done: assert property (calm ##0 rd_trn |=> rd_data[15] == $past(status_in[9]))
    else $error("training done bit wrong");
  a_tap_status: assert property (calm ##0 rd_trn |=> rd_data[4:0] == $past(status_in[7:3]))
    else $error("tap status wrong");
  a_gig_capable: assert property (rd_gig |=> rd_data[13:12] == 2'h3)
    else $error("fault capability bits wrong");
  a_fault_seen: assert property (calm ##0 rd_gig |=> (~rd_data[11:10] & $past(status_in[2:1])) == 2'h0)
    else $error("present fault not reported");
  a_sig_detect: assert property (calm ##0 rd_gig |=> rd_data[0] == $past(status_in[0]))
    else $error("signal detect bit wrong");
  a_cap_const: assert property (rd_stb && addr == kfs_pkg::OFS_FEC_CAPABILITY |=> rd_data == 16'h0003)
    else $error("capability value wrong");
  a_ctl_write: assert property (wr_ctl |=> fec_ctl == {$past(wr_data[0]), $past(wr_data[1])})
    else $error("control write not applied");
  a_ctl_hold: assert property (!wr_ctl |=> $stable(fec_ctl))
    else $error("control changed without write");
  a_ctl_read: assert property (rd_ctl |=> rd_data == {14'h0000, fec_ctl[0], fec_ctl[1]})
    else $error("control readback wrong");
  c_ctl_write: cover property (wr_ctl);
  c_fault_read: cover property (rd_gig ##1 rd_data[11]);
  c_low_read: cover property (rd_stb && addr == kfs_pkg::OFS_FEC_CORR_LOW);
endmodule : kfs_chk

// ---- verification/kfs_station.sv ----
// station model: management reads and writes of the bank
module kfs_station (
  input wire logic clock,
  output logic rd_stb,
  output logic wr_stb,
  output logic [15:0] addr,
  output logic [15:0] wr_data,
  input wire logic [15:0] rd_data,
  input wire logic rd_valid
);
  timeunit 1ns;
  timeprecision 1ns;
  bit hung = 0;
  initial begin
    {rd_stb, wr_stb, addr, wr_data} = '0;
  end
  // released lines flip so stale values never look valid
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    @(negedge clock);
    {wr_stb, addr, wr_data} = {1'b1, a, d};
    @(negedge clock);
    {wr_stb, addr, wr_data} = {1'b0, ~a, ~d};
  endtask : wr
  task automatic rd(input logic [15:0] a, output logic [15:0] d);
    @(negedge clock);
    {rd_stb, addr} = {1'b1, a};
    @(negedge clock);
    {rd_stb, addr} = {1'b0, ~a};
    for (int i = 0; i < 4 && !rd_valid; i++)
      @(negedge clock);
    hung |= !rd_valid;
    d = rd_data;
  endtask : rd
endmodule : kfs_station

// ---- verification/kfs_regs_tb_top.sv ----
// testbench: station traffic against a behavioural bank model
module kfs_regs_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic clock = 0;
  logic rst_n = 0;
  logic rd_stb, wr_stb, rd_valid;
  logic [15:0] addr, wr_data, rd_data, d, w;
  kfs_pkg::kfs_status_t st = '0;
  kfs_pkg::kfs_fec_evt_t ev = '0;
  kfs_pkg::kfs_fec_ctl_t ctl;
  int miscompares = 0;
  int total_checks = 0;
  int seed = 32'h8045_40c3;
  int cnt[2] = '{0, 0};
  int hold[2] = '{0, 0};
  bit hv[2] = '{0, 0};
  bit mtx = 0;
  bit mrx = 0;
  logic [1:0] mctl = 2'h0;
  logic [15:0] regs[9] = '{16'h009b, 16'h00a1, 16'h00aa, 16'h00ab, 16'h00ac, 16'h00ad,
    16'h00ae, 16'h00af, 16'h00b0};
  kfs_regs i_kfs_regs (.clock(clock), .rst_n(rst_n), .rd_stb(rd_stb), .wr_stb(wr_stb),
    .addr(addr), .wr_data(wr_data), .rd_data(rd_data), .rd_valid(rd_valid),
    .status_in(st), .fec_evt(ev), .fec_ctl(ctl));
  kfs_station i_kfs_station (.clock(clock), .rd_stb(rd_stb), .wr_stb(wr_stb),
    .addr(addr), .wr_data(wr_data), .rd_data(rd_data), .rd_valid(rd_valid));
  initial begin
    forever #10 clock = ~clock;
  end
  function automatic logic [15:0] model(input logic [15:0] a);
    int k;
    k = a[1];
    model = 16'h0000;
    case (a)
      16'h009b: model = {st[9], 10'h000, st[7:3]};
      16'h00a1: begin
        model = {4'h3, mtx, mrx, 9'h000, st[0]};
        mtx = st[2];
        mrx = st[1];
      end
      16'h00aa: model = 16'h0003;
      16'h00ab: model = {14'h0000, mctl};
      16'h00ac, 16'h00ae: begin
        model = cnt[k][15:0];
        hold[k] = cnt[k] >> 16;
        hv[k] = 1;
        cnt[k] = 0;
      end
      16'h00ad, 16'h00af: begin
        model = hv[k] ? hold[k][15:0] : cnt[k][31:16];
        if (!hv[k])
          cnt[k] = cnt[k] & 32'h0000_ffff;
        hv[k] = 0;
      end
      default: model = 16'h0000;
    endcase
  endfunction : model
  task automatic chk_rd(input logic [15:0] a, input logic [15:0] e, input logic [15:0] g);
    total_checks++;
    if (g !== e) begin
      miscompares++;
      $display("[ERR] rd_data %h expected %h seen %h", a, e, g);
    end
  endtask : chk_rd
  task automatic chk_ctl(input logic [1:0] e, input logic [1:0] g);
    total_checks++;
    if (g !== e) begin
      miscompares++;
      $display("[ERR] fec_ctl expected %h seen %h", e, g);
    end
  endtask : chk_ctl
  task automatic rdc(input logic [15:0] a);
    i_kfs_station.rd(a, d);
    chk_rd(a, model(a), d);
    if (i_kfs_station.hung)
      end_of_test();
  endtask : rdc
  task automatic pulse(input int n);
    repeat (n) begin
      @(negedge clock);
      ev = {1'b1, 1'($random(seed))};
      cnt[0] += 1;
      cnt[1] += ev[0];
    end
    @(negedge clock);
    ev = '0;
  endtask : pulse
  task automatic end_of_test;
    miscompares += i_kfs_station.hung;
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : end_of_test
  initial begin
    repeat (12) @(negedge clock);
    rst_n = 1;
    repeat (3) @(negedge clock);
    foreach (regs[i]) rdc(regs[i]);
    for (int i = 0; i < 5; i++) begin
      w = 16'($random(seed));
      w[1:0] = i[1:0];
      i_kfs_station.wr(i == 4 ? 16'h00aa : 16'h00ab, w);
      mctl = i < 4 ? w[1:0] : mctl;
      chk_ctl(mctl, {ctl[0], ctl[1]});
      rdc(16'h00ab);
    end
    for (int i = 0; i < 8; i++) begin
      st = 10'($random(seed));
      st.local_pre_tap_status = i[1:0];
      st.local_main_tap_status = ~i[1:0];
      mtx |= st[2];
      mrx |= st[1];
      repeat (4) @(negedge clock);
      rdc(16'h009b);
      rdc(16'h00a1);
      rdc(16'h00a1);
    end
    pulse(65541);
    rdc(16'h00ac);
    pulse(3);
    rdc(16'h00ad);
    rdc(16'h00ae);
    rdc(16'h00af);
    rdc(16'h00ad);
    rdc(16'h00ac);
    end_of_test();
  end
endmodule : kfs_regs_tb_top
bind kfs_regs kfs_chk i_kfs_chk (.clock(clock), .rst_n(rst_n), .rd_stb(rd_stb),
  .wr_stb(wr_stb), .addr(addr), .wr_data(wr_data), .rd_data(rd_data), .rd_valid(rd_valid),
  .status_in(status_in), .fec_evt(fec_evt), .fec_ctl(fec_ctl));
